// ---- msc_modem_ctrl.sv ----
// Two-channel RS-232 modem line monitor and RTS/DTR override
`timescale 1ns/1ps
// Overview of operation
// - Per channel read-only status word: RTS,DSR,DTR,CD,CTS,RI in bits 0-5.
// - By default RTS and DTR follow their designation bits, both ON after reset.
// - Designation bits force RTS/DTR unless an override applies.
// - Half-duplex or modem timing control keeps RTS under device control.
// - DTR/DSR flow control or modem data keeps DTR under device control.
// - New designated level reaches the line within 0 to 20 ms.
// - Protocols 204 to 207 set or clear the matching designation bit.
// - Without modem timing control, full duplex: RTS is the designation bit ANDed with ready flag; half duplex: RTS while sending.
// - Without DTR/DSR flow control or modem data, DTR follows its designation bit.
module msc_modem_ctrl (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Buffer memory port
  input  wire logic [9:0] bm_addr,
  input  wire logic       bm_wr,
  input  wire logic       bm_rd,
  input  wire logic [15:0] bm_wdata,
  output logic      [15:0] bm_rdata,
  // Protocol execution request
  input  wire logic       protocol_execute_instruction,
  input  wire logic       proto_ch,
  input  wire logic [7:0] proto_num,
  // Device state
  input  wire logic       module_ready_flag,
  input  wire logic [1:0] half_duplex,
  input  wire logic [1:0] modem_rts_ctrl,
  input  wire logic [1:0] modem_dtr_ctrl,
  input  wire logic [1:0] dtr_flow_en,
  input  wire logic [1:0] tx_active,
  input  wire logic [1:0] rx_space_ok,
  input  wire logic [1:0] modem_rts_level,
  input  wire logic [1:0] modem_dtr_level,
  // RS-232 pins
  input  wire logic [1:0] dsr_pin,
  input  wire logic [1:0] cd_pin,
  input  wire logic [1:0] cts_pin,
  input  wire logic [1:0] ri_pin,
  output logic      [1:0] rts_pin,
  output logic      [1:0] dtr_pin
);
  import msc_pkg::*;

  // ==========================================================
  // Millisecond tick divider shared by both channels
  // A designation takes effect on the next tick, so the line lags a
  // software write by at most one millisecond and one clock, inside the 20 ms limit.
  logic [15:0] div_reg;
  wire         tick_ms = (div_reg == 16'(MSC_TICK_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      div_reg <= 16'h0000;
    else if (tick_ms)
      div_reg <= 16'h0000;
    else
      div_reg <= div_reg + 16'h0001;
  end

  // ==========================================================
  // Decode helpers shared by the bus and both channels
  function automatic logic addr_hit(input logic [9:0] a,
                                    input logic [9:0] ofs);
    return a == ofs;
  endfunction

  // Protocol commands patch one bit; other numbers leave the word alone
  function automatic logic [15:0] proto_patch(input logic [15:0] w,
                                              input logic [7:0]  num);
    logic [15:0] r;
    r = w;
    case (num)
      MSC_PROTO_RTS_ON:  r[MSC_FD_RTS] = 1'b1;
      MSC_PROTO_RTS_OFF: r[MSC_FD_RTS] = 1'b0;
      MSC_PROTO_DTR_ON:  r[MSC_FD_DTR] = 1'b1;
      MSC_PROTO_DTR_OFF: r[MSC_FD_DTR] = 1'b0;
      default:           r = w;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Per channel logic
  logic [15:0] force_reg  [2];
  logic [15:0] status_reg [2];
  // Offsets as arrays so the channel loop can index them
  logic [9:0]  force_ofs  [2];
  logic [9:0]  status_ofs [2];
  assign force_ofs[0]  = MSC_CH1_FORCE_OFS;
  assign force_ofs[1]  = MSC_CH2_FORCE_OFS;
  assign status_ofs[0] = MSC_CH1_STATUS_OFS;
  assign status_ofs[1] = MSC_CH2_STATUS_OFS;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_ch
      logic [3:0]  in_s1_reg;
      logic [3:0]  in_s2_reg;
      logic [1:0]  applied_reg;
      logic [15:0] force_next;
      logic [15:0] status_next;
      logic        rts_own;
      logic        dtr_own;
      logic        rts_auto;
      logic        dtr_auto;
      logic        rts_next;
      logic        dtr_next;

      wire wr_hit = bm_wr && addr_hit(bm_addr, force_ofs[g]);
      wire pr_hit = protocol_execute_instruction && (proto_ch == 1'(g));

      // ====================================================
      // Designation word; a protocol wins over a same-cycle write
      always_comb begin
        force_next = wr_hit ? bm_wdata : force_reg[g];
        if (pr_hit)
          force_next = proto_patch(force_next, proto_num);
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
          force_reg[g] <= MSC_FORCE_RST;
        else
          force_reg[g] <= force_next;
      end

      // ====================================================
      // Designation reaches the line driver at the next tick
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
          applied_reg <= MSC_FORCE_RST[1:0];
        else if (tick_ms)
          applied_reg <= {force_reg[g][MSC_FD_DTR],
                          force_reg[g][MSC_FD_RTS]};
      end

      // ====================================================
      // Line ownership
      // Half duplex or modem timing takes RTS from software; flow
      // control or modem data exchange takes DTR from software
      assign rts_own  = half_duplex[g] || modem_rts_ctrl[g];
      assign dtr_own  = dtr_flow_en[g] || modem_dtr_ctrl[g];
      assign rts_auto = modem_rts_ctrl[g] ? modem_rts_level[g] :
                        half_duplex[g] ? tx_active[g] :
                        module_ready_flag;
      assign dtr_auto = modem_dtr_ctrl[g] ? modem_dtr_level[g] :
                        dtr_flow_en[g] ? rx_space_ok[g] : 1'b1;
      // Unowned lines follow the applied designation; RTS is still gated
      // by ready so a forced ON never announces a module that cannot send
      assign rts_next = rts_own ? rts_auto
                                : (applied_reg[0] & module_ready_flag);
      assign dtr_next = dtr_own ? dtr_auto : applied_reg[1];

      // ====================================================
      // Two-flop synchroniser for the incoming lines
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          in_s1_reg <= 4'h0;
          in_s2_reg <= 4'h0;
        end else begin
          in_s1_reg <= {ri_pin[g], cts_pin[g], cd_pin[g], dsr_pin[g]};
          in_s2_reg <= in_s1_reg;
        end
      end

      // Registered line drivers
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          rts_pin[g] <= 1'b0;
          dtr_pin[g] <= 1'b0;
        end else begin
          rts_pin[g] <= rts_next;
          dtr_pin[g] <= dtr_next;
        end
      end

      // ====================================================
      // Live status word; bits 6 to 15 stay zero
      // Driven lines are reported as driven, inputs after synchronising
      always_comb begin
        status_next = MSC_STATUS_RST;
        status_next[MSC_ST_RTS] = rts_pin[g];
        status_next[MSC_ST_DSR] = in_s2_reg[0];
        status_next[MSC_ST_DTR] = dtr_pin[g];
        status_next[MSC_ST_CD]  = in_s2_reg[1];
        status_next[MSC_ST_CTS] = in_s2_reg[2];
        status_next[MSC_ST_RI]  = in_s2_reg[3];
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
          status_reg[g] <= MSC_STATUS_RST;
        else
          status_reg[g] <= status_next;
      end
    end
  endgenerate

  // ==========================================================
  // Read data path, registered; unmapped addresses read zero
  // Reads are registered so bm_rdata stands until the next read strobe
  wire        rd_f1  = addr_hit(bm_addr, force_ofs[0]);
  wire        rd_f2  = addr_hit(bm_addr, force_ofs[1]);
  wire        rd_s1  = addr_hit(bm_addr, status_ofs[0]);
  wire        rd_s2  = addr_hit(bm_addr, status_ofs[1]);
  wire [15:0] rd_mux = rd_f1 ? force_reg[0]  :
                       rd_f2 ? force_reg[1]  :
                       rd_s1 ? status_reg[0] :
                       rd_s2 ? status_reg[1] : 16'h0000;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      bm_rdata <= 16'h0000;
    else if (bm_rd)
      bm_rdata <= rd_mux;
  end
endmodule

// ---- msc_pkg.sv ----
// Package with register map, field positions and timing for modem line control
package msc_pkg;
  // ==========================================================
  // Register offsets (buffer memory word addresses)
  localparam logic [9:0] MSC_CH1_FORCE_OFS  = 10'h092;
  localparam logic [9:0] MSC_CH2_FORCE_OFS  = 10'h132;
  localparam logic [9:0] MSC_CH1_STATUS_OFS = 10'h254;
  localparam logic [9:0] MSC_CH2_STATUS_OFS = 10'h264;
  // ==========================================================
  // Status word bit positions
  localparam int MSC_ST_RTS = 0;
  localparam int MSC_ST_DSR = 1;
  localparam int MSC_ST_DTR = 2;
  localparam int MSC_ST_CD  = 3;
  localparam int MSC_ST_CTS = 4;
  localparam int MSC_ST_RI  = 5;
  // Designation word bit positions
  localparam int MSC_FD_RTS = 0;
  localparam int MSC_FD_DTR = 1;
  // ==========================================================
  // Reset values
  localparam logic [15:0] MSC_FORCE_RST  = 16'h0003;
  localparam logic [15:0] MSC_STATUS_RST = 16'h0000;
  // ==========================================================
  // Timing: reflection lag lies within 0 to 20 ms
  localparam int MSC_CLK_HZ       = 10000000;
  localparam int MSC_LAG_MAX_MS   = 20;
  localparam int MSC_TICK_US      = 1000;
  localparam int MSC_TICK_CYCLES  = MSC_CLK_HZ / 1000000 * MSC_TICK_US;
  localparam int MSC_LAG_TICKS    = MSC_LAG_MAX_MS * 1000 / MSC_TICK_US;
  // ==========================================================
  // Functional protocol numbers for line designation
  localparam logic [7:0] MSC_PROTO_RTS_ON  = 8'hCC;
  localparam logic [7:0] MSC_PROTO_RTS_OFF = 8'hCD;
  localparam logic [7:0] MSC_PROTO_DTR_ON  = 8'hCE;
  localparam logic [7:0] MSC_PROTO_DTR_OFF = 8'hCF;
endpackage

// ---- msc_modem_ctrl_chk.sv ----
// Checker for the modem line control block ports
`timescale 1ns/1ps
module msc_modem_ctrl_chk (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [9:0]  bm_addr,
  input wire logic        bm_rd,
  input wire logic [15:0] bm_rdata,
  input wire logic        module_ready_flag,
  input wire logic [1:0]  half_duplex,
  input wire logic [1:0]  modem_rts_ctrl,
  input wire logic [1:0]  modem_dtr_ctrl,
  input wire logic [1:0]  dtr_flow_en,
  input wire logic [1:0]  tx_active,
  input wire logic [1:0]  rx_space_ok,
  input wire logic [1:0]  modem_rts_level,
  input wire logic [1:0]  modem_dtr_level,
  input wire logic [1:0]  cts_pin,
  input wire logic [1:0]  rts_pin,
  input wire logic [1:0]  dtr_pin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Line ownership and register port
  rts_half_a: assert property (half_duplex[0] && !modem_rts_ctrl[0]
    |=> rts_pin[0] == $past(tx_active[0])) else $error("rts off tx");
  rts_modem_a: assert property (modem_rts_ctrl[0]
    |=> rts_pin[0] == $past(modem_rts_level[0])) else $error("rts off modem");
  dtr_modem_a: assert property (modem_dtr_ctrl[1]
    |=> dtr_pin[1] == $past(modem_dtr_level[1])) else $error("dtr off modem");
  dtr_flow_a: assert property (dtr_flow_en[0] && !modem_dtr_ctrl[0]
    |=> dtr_pin[0] == $past(rx_space_ok[0])) else $error("dtr off space");
  rts_ready_a: assert property (!module_ready_flag && !half_duplex[0]
    && !modem_rts_ctrl[0] |=> !rts_pin[0]) else $error("rts without ready");
  stat_unused_a: assert property (bm_rd && (bm_addr == 10'h254
    || bm_addr == 10'h264) |=> bm_rdata[15:6] == 10'h000)
    else $error("unused status bits set");
  unmapped_rd_a: assert property (bm_rd && bm_addr == 10'h000
    |=> bm_rdata == 16'h0000) else $error("unmapped read nonzero");
  stat_cts_a: assert property ($stable(cts_pin)[*6] ##0
    (bm_rd && bm_addr == 10'h254) |=> bm_rdata[4] == $past(cts_pin[0]))
    else $error("cts status stale");
endmodule
bind msc_modem_ctrl msc_modem_ctrl_chk msc_modem_ctrl_chk_inst (.*);

// ---- msc_line_peer.sv ----
// External RS-232 device model driving the modem input lines
`timescale 1ns/1ps
module msc_line_peer (
  input wire logic       core_clk,
  input wire logic [7:0] lvl,
  output logic     [1:0] dsr_pin,
  output logic     [1:0] cd_pin,
  output logic     [1:0] cts_pin,
  output logic     [1:0] ri_pin
);
  // ==========================================================
  // Lines change just after a clock edge
  always @(posedge core_clk) {ri_pin, cts_pin, cd_pin, dsr_pin} <= lvl;
endmodule

// ---- msc_modem_ctrl_tb.sv ----
// Testbench for the modem line control block
`timescale 1ns/1ps
module msc_modem_ctrl_tb;
  import msc_pkg::*;
  logic core_clk = 0, rst_n = 0, bm_wr = 0, bm_rd = 0, module_ready_flag = 1;
  logic protocol_execute_instruction = 0, proto_ch = 0;
  logic [9:0] bm_addr = 10'h000;
  logic [15:0] bm_wdata = 16'h0000, bm_rdata;
  logic [7:0] proto_num = 8'h00, lvl = 8'h00;
  logic [1:0] half_duplex = 0, modem_rts_ctrl = 0, modem_dtr_ctrl = 0;
  logic [1:0] dtr_flow_en = 0, tx_active = 0, rx_space_ok = 0;
  logic [1:0] modem_rts_level = 0, modem_dtr_level = 0;
  logic [1:0] dsr_pin, cd_pin, cts_pin, ri_pin, rts_pin, dtr_pin;
  int n_fail = 0, checks = 0;
  msc_modem_ctrl msc_modem_ctrl_inst (.*);
  msc_line_peer msc_line_peer_inst (.*);
  always #50 core_clk = ~core_clk;
  // ==========================================================
  // Bus cycles and comparison
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge core_clk) {bm_addr, bm_wdata, bm_wr} <= {a, d, 1'b1};
    @(posedge core_clk) bm_wr <= 0;
  endtask
  task rd(input logic [9:0] a, input logic [15:0] e);
    @(posedge core_clk) {bm_addr, bm_rd} <= {a, 1'b1};
    @(posedge core_clk) bm_rd <= 0;
    @(posedge core_clk) #1 chk("rdata", e, bm_rdata);
  endtask
  task pins(input logic [3:0] e);
    repeat (3) @(posedge core_clk);
    #1 chk("pins", {12'h000, e}, {12'h000, dtr_pin, rts_pin});
  endtask
  task t_def; pins(4'hF); endtask
  task t_reg;
    rd(MSC_CH1_FORCE_OFS, MSC_FORCE_RST);
    wr(MSC_CH1_FORCE_OFS, 16'h0000);
    wr(MSC_CH2_FORCE_OFS, 16'h0002);
    rd(MSC_CH1_FORCE_OFS, 16'h0000);
    rd(MSC_CH2_FORCE_OFS, 16'h0002);
    rd(10'h000, 16'h0000);
  endtask
  task t_proto;
    logic [7:0] nums [5];
    logic [15:0] exp_v [5];
    nums = '{8'd204, 8'd206, 8'd205, 8'd208, 8'd207};
    exp_v = '{16'h1, 16'h3, 16'h2, 16'h2, 16'h0};
    for (int c = 0; c < 2; c++) begin
      wr(c ? MSC_CH2_FORCE_OFS : MSC_CH1_FORCE_OFS, 16'h0000);
      for (int k = 0; k < 5; k++) begin
        @(posedge core_clk) {proto_ch, proto_num} <= {c[0], nums[k]};
        protocol_execute_instruction <= 1;
        @(posedge core_clk) protocol_execute_instruction <= 0;
        rd(c ? MSC_CH2_FORCE_OFS : MSC_CH1_FORCE_OFS, exp_v[k]);
      end
    end
  endtask
  task t_own;
    @(posedge core_clk) {module_ready_flag, half_duplex} <= 3'b000;
    pins(4'hC);
    @(posedge core_clk) {modem_rts_ctrl, modem_rts_level} <= 4'hE;
    {modem_dtr_ctrl, modem_dtr_level} <= 4'hD;
    pins(4'h6);
    @(posedge core_clk) {modem_rts_ctrl, modem_dtr_ctrl} <= 4'h0;
    {half_duplex, tx_active, dtr_flow_en, rx_space_ok} <= 8'hDE;
    pins(4'h9);
  endtask
  task t_stat;
    @(posedge core_clk) lvl <= 8'h99;
    wr(MSC_CH1_STATUS_OFS, 16'hFFFF);
    repeat (6) @(posedge core_clk);
    rd(MSC_CH1_STATUS_OFS, 16'h0013);
    rd(MSC_CH2_STATUS_OFS, 16'h002C);
  endtask
  task t_lag;
    int n;
    @(posedge core_clk) {module_ready_flag, half_duplex, dtr_flow_en} <= 5'h10;
    wr(MSC_CH1_FORCE_OFS, 16'h0002);
    wr(MSC_CH2_FORCE_OFS, 16'h0001);
    n = 0;
    while ({dtr_pin, rts_pin} !== 4'h6 && n < MSC_TICK_CYCLES + 4) begin
      @(posedge core_clk) #1;
      n++;
    end
    chk("lag", 16'h0006, {12'h000, dtr_pin, rts_pin});
    if (n >= MSC_TICK_CYCLES + 4) end_of_test();
  endtask
  task end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1;
    t_def();
    t_reg();
    t_proto();
    t_own();
    t_stat();
    t_lag();
    end_of_test();
  end
endmodule
